// >>> irq_defs.svh
// Purpose: Constants for the interrupt request and vector mapping logic
// Assumes: One clock, mclk at 50 MHz; asynchronous active-high reset
// Notes: Flag and request vectors are indexed by vector number
`ifndef IRQ_DEFS_SVH
`define IRQ_DEFS_SVH
// Overview of operation
// - Peripheral event sets its own flag bit
// - Each maskable source has its own enable bit; vector 1 ignores its enable bit
// - Maskable request only when flag and enable set; vector 1 needs only its flag
// - Request holds while its flag and enables stay set
// - Global enable gates every maskable request
// - Each vector except 0 and 5 fed by exactly one peripheral
// - Vector 0 reset, vector 1 unmaskable checksum
// - Vector 2 carries voltage monitor request
// - Vectors 3 and 4 carry port pin changes
// - Vector 6 carries real-time counter request
// - Vector 7 carries periodic tick request
// - Vector 8 overflow, or low underflow in split
// - Vector 9 high underflow in split mode
// - Vectors 10 to 12 timer A compares
// - Vector 13 carries timer B request

// Vector numbers
`define VEC_RESET 4'h0
`define VEC_CHECKSUM 4'h1
`define VEC_VOLTAGE 4'h2
`define VEC_FIRST_PORT 4'h3
`define VEC_SECOND_PORT 4'h4
`define VEC_RTC_COUNTER 4'h6
`define VEC_PERIODIC 4'h7
`define VEC_TIMER_A_OVF 4'h8
`define VEC_TIMER_A_HUNF 4'h9
`define VEC_TIMER_A_CMP0 4'ha
`define VEC_TIMER_B 4'hd

// Widths and masks
`define VEC_COUNT 14
`define VEC_W 4
`define CMP_CHANNELS 3
`define FLAGS_RESET 14'h0000
`define NONMASKABLE_MASK 14'h0002
`define MASKABLE_MASK 14'h3fdc
`define IMPLEMENTED_MASK 14'h3fde
`endif

// >>> irq_types_pkg.sv
// Purpose: Types for the interrupt request and vector mapping logic
// Assumes: irq_defs.svh supplies widths
// Notes: Event fields are one-cycle pulses from the peripherals
`default_nettype none
`include "irq_defs.svh"

package irq_types_pkg;

	// Timer A counting mode
	typedef enum logic {
		timer_a_normal_mode,
		timer_a_split_mode
	} timer_a_mode_type;

	// Peripheral interrupt conditions
	typedef struct packed {
		logic checksum_scan_nonmaskable_irq;
		logic voltage_monitor_irq;
		logic first_port_pin_irq;
		logic second_port_pin_irq;
		logic rtc_counter_irq;
		logic periodic_tick_irq;
		logic timer_a_overflow_irq;
		logic timer_a_low_underflow_irq;
		logic timer_a_high_underflow_irq;
		logic [`CMP_CHANNELS-1:0] timer_a_compare_irq;
		logic [`CMP_CHANNELS-1:0] timer_a_low_compare_irq;
		logic timer_b_irq;
	} irq_event_type;

	// Request presented to the processor core
	typedef struct packed {
		logic valid;
		logic nonmaskable;
		logic [`VEC_W-1:0] vector;
	} core_request_type;

endpackage : irq_types_pkg

`default_nettype wire

// >>> irq_vector_logic.sv
// Purpose: Interrupt flags, enables and vector selection for the core
// Assumes: Events, enables and clears are synchronous to mclk
// Notes: A set in the same cycle as a clear leaves the flag set
`timescale 1ns/1ps
`default_nettype none
`include "irq_defs.svh"

module irq_vector_logic
	import irq_types_pkg::*;
#(
	parameter int NUM_VECTORS = `VEC_COUNT
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Peripheral events
	input wire irq_event_type events,
	input wire timer_a_mode_type timer_a_mode,
	// Software control
	input wire logic global_enable,
	input wire logic [NUM_VECTORS-1:0] peripheral_irq_enable_register,
	input wire logic [NUM_VECTORS-1:0] flag_clear,
	// Software status
	output logic [NUM_VECTORS-1:0] peripheral_flag_register,
	// Processor core side
	output logic [NUM_VECTORS-1:0] irq_request,
	output core_request_type core_request,
	output logic reset_entry
);

	// Per-vector set pulses from the peripheral events
	function automatic logic [NUM_VECTORS-1:0] map_events(
		input irq_event_type ev,
		input timer_a_mode_type mode
	);
		logic [NUM_VECTORS-1:0] v;
		logic split;
		v = '0;
		split = (mode == timer_a_split_mode);
		v[`VEC_CHECKSUM] = ev.checksum_scan_nonmaskable_irq;
		v[`VEC_VOLTAGE] = ev.voltage_monitor_irq;
		v[`VEC_FIRST_PORT] = ev.first_port_pin_irq;
		v[`VEC_SECOND_PORT] = ev.second_port_pin_irq;
		v[`VEC_RTC_COUNTER] = ev.rtc_counter_irq;
		v[`VEC_PERIODIC] = ev.periodic_tick_irq;
		// Low underflow replaces overflow in split mode
		v[`VEC_TIMER_A_OVF] = split ? ev.timer_a_low_underflow_irq
			: ev.timer_a_overflow_irq;
		v[`VEC_TIMER_A_HUNF] = split & ev.timer_a_high_underflow_irq;
		for (int i = 0; i < `CMP_CHANNELS; i++) begin
			v[int'(`VEC_TIMER_A_CMP0) + i] = split ? ev.timer_a_low_compare_irq[i]
				: ev.timer_a_compare_irq[i];
		end
		v[`VEC_TIMER_B] = ev.timer_b_irq;
		return v;
	endfunction : map_events

	// Lowest-numbered set bit
	function automatic logic [`VEC_W-1:0] lowest_pending(
		input logic [NUM_VECTORS-1:0] req
	);
		logic [`VEC_W-1:0] idx;
		idx = '0;
		for (int i = NUM_VECTORS - 1; i >= 0; i--) begin
			if (req[i]) begin
				idx = `VEC_W'(i);
			end
		end
		return idx;
	endfunction : lowest_pending

	logic [NUM_VECTORS-1:0] flag_reg, flag_next;
	logic [NUM_VECTORS-1:0] request_reg, request_next;
	core_request_type core_reg, core_next;
	logic reset_entry_reg, reset_entry_next;
	logic [NUM_VECTORS-1:0] set_pulse;
	logic [NUM_VECTORS-1:0] gate;

	always_comb begin
		set_pulse = map_events(events, timer_a_mode);
		// Set wins over a clear in the same cycle
		flag_next = ((flag_reg & ~flag_clear) | set_pulse)
			& `IMPLEMENTED_MASK;
		// Maskable sources need their own and the global enable
		gate = peripheral_irq_enable_register
			& {NUM_VECTORS{global_enable}}
			& `MASKABLE_MASK;
		// Request follows flag and gate, so it drops when the flag or a maskable source's enables clear
		request_next = (flag_next & gate)
			| (flag_next & `NONMASKABLE_MASK);
		core_next.valid = |request_next;
		core_next.nonmaskable = request_next[`VEC_CHECKSUM];
		core_next.vector = lowest_pending(request_next);
		reset_entry_next = 1'b0;
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			flag_reg <= `FLAGS_RESET;
			request_reg <= `FLAGS_RESET;
			core_reg <= '{valid: 1'b0, nonmaskable: 1'b0, vector: `VEC_RESET};
			reset_entry_reg <= 1'b1;
		end else begin
			flag_reg <= flag_next;
			request_reg <= request_next;
			core_reg <= core_next;
			reset_entry_reg <= reset_entry_next;
		end
	end

	assign peripheral_flag_register = flag_reg;
	assign irq_request = request_reg;
	assign core_request = core_reg;
	assign reset_entry = reset_entry_reg;

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);

	AST_FLAG_SET: assert property (
		events.rtc_counter_irq |=> peripheral_flag_register[`VEC_RTC_COUNTER]
	) else $error("Counter event did not set its flag");

	AST_ENABLE_GATE: assert property (
		1'b1 |=> ((irq_request & ~$past(peripheral_irq_enable_register)
			& `MASKABLE_MASK) == '0)
	) else $error("Request raised for a disabled source");

	AST_REQ_NEEDS_FLAG: assert property (
		(irq_request & ~peripheral_flag_register) == '0
	) else $error("Request without its flag");

	AST_REQ_HOLDS: assert property (
		(global_enable && peripheral_irq_enable_register[`VEC_PERIODIC]
			&& peripheral_flag_register[`VEC_PERIODIC]
			&& !flag_clear[`VEC_PERIODIC])
		|=> irq_request[`VEC_PERIODIC] && peripheral_flag_register[`VEC_PERIODIC]
	) else $error("Request dropped while flag still set");

	AST_GLOBAL_OFF: assert property (
		!global_enable |=> ((irq_request & `MASKABLE_MASK) == '0)
	) else $error("Maskable request while globally disabled");

	AST_UNUSED_VECTORS: assert property (
		!irq_request[`VEC_RESET] && !irq_request[5] && !peripheral_flag_register[5]
	) else $error("Unmapped vector became active");

	AST_NMI_UNMASKED: assert property (
		events.checksum_scan_nonmaskable_irq
		|=> irq_request[`VEC_CHECKSUM] && core_request.nonmaskable
			&& core_request.vector == `VEC_CHECKSUM
	) else $error("Checksum request not presented unmasked");

	AST_RESET_ENTRY: assert property (
		$fell(rst) |-> reset_entry && core_request == '0 ##1 !reset_entry
	) else $error("Reset entry not on vector zero for one cycle");

	AST_VOLTAGE: assert property (
		(events.voltage_monitor_irq && global_enable
			&& peripheral_irq_enable_register[`VEC_VOLTAGE])
		|=> irq_request[`VEC_VOLTAGE]
	) else $error("Voltage monitor request missing");

	AST_PORTS: assert property (
		(events.second_port_pin_irq && global_enable
			&& peripheral_irq_enable_register[`VEC_SECOND_PORT])
		|=> irq_request[`VEC_SECOND_PORT]
	) else $error("Second port request missing");

	AST_SPLIT_OVF: assert property (
		(timer_a_mode == timer_a_split_mode && !events.timer_a_low_underflow_irq
			&& !peripheral_flag_register[`VEC_TIMER_A_OVF])
		|=> !peripheral_flag_register[`VEC_TIMER_A_OVF]
	) else $error("Overflow reached vector eight in split mode");

	AST_HUNF_NORMAL: assert property (
		(timer_a_mode == timer_a_normal_mode
			&& !peripheral_flag_register[`VEC_TIMER_A_HUNF])
		|=> !peripheral_flag_register[`VEC_TIMER_A_HUNF]
	) else $error("High underflow flagged in normal mode");

	AST_COMPARE: assert property (
		(timer_a_mode == timer_a_normal_mode && events.timer_a_compare_irq[2])
		|=> peripheral_flag_register[12]
	) else $error("Compare channel two flag missing");

	AST_TIMER_B: assert property (
		events.timer_b_irq |=> peripheral_flag_register[`VEC_TIMER_B]
	) else $error("Timer B flag missing");

	AST_LOWEST_FIRST: assert property (
		core_request.valid |-> irq_request[core_request.vector]
			&& ((irq_request & ((14'h1 << core_request.vector) - 14'h1)) == '0)
	) else $error("Presented vector is not the lowest pending");

	AST_FIRST_PORT: assert property (
		(events.first_port_pin_irq && global_enable
			&& peripheral_irq_enable_register[`VEC_FIRST_PORT])
		|=> irq_request[`VEC_FIRST_PORT]
	) else $error("First port request missing");

	AST_RTC_REQ: assert property (
		(events.rtc_counter_irq && global_enable
			&& peripheral_irq_enable_register[`VEC_RTC_COUNTER])
		|=> irq_request[`VEC_RTC_COUNTER]
	) else $error("Counter request missing");

	AST_TICK_REQ: assert property (
		(events.periodic_tick_irq && global_enable
			&& peripheral_irq_enable_register[`VEC_PERIODIC])
		|=> irq_request[`VEC_PERIODIC]
	) else $error("Periodic tick request missing");

	AST_NORMAL_OVF: assert property (
		(timer_a_mode == timer_a_normal_mode && events.timer_a_overflow_irq)
		|=> peripheral_flag_register[`VEC_TIMER_A_OVF]
	) else $error("Overflow flag missing in normal mode");

	AST_SPLIT_LUNF: assert property (
		(timer_a_mode == timer_a_split_mode && events.timer_a_low_underflow_irq)
		|=> peripheral_flag_register[`VEC_TIMER_A_OVF]
	) else $error("Low underflow flag missing in split mode");

	AST_HUNF_SPLIT: assert property (
		(timer_a_mode == timer_a_split_mode && events.timer_a_high_underflow_irq)
		|=> peripheral_flag_register[`VEC_TIMER_A_HUNF]
	) else $error("High underflow flag missing in split mode");

	AST_LOW_COMPARE: assert property (
		(timer_a_mode == timer_a_split_mode && events.timer_a_low_compare_irq[0])
		|=> peripheral_flag_register[`VEC_TIMER_A_CMP0]
	) else $error("Low compare channel zero flag missing");

	AST_SPLIT_CMP_IGNORED: assert property (
		(timer_a_mode == timer_a_split_mode && !events.timer_a_low_compare_irq[1]
			&& !peripheral_flag_register[11])
		|=> !peripheral_flag_register[11]
	) else $error("Normal compare reached vector eleven in split mode");

	AST_TIMER_B_REQ: assert property (
		(events.timer_b_irq && global_enable
			&& peripheral_irq_enable_register[`VEC_TIMER_B])
		|=> irq_request[`VEC_TIMER_B]
	) else $error("Timer B request missing");

	AST_CLEAR_DROPS: assert property (
		(flag_clear[`VEC_RTC_COUNTER] && !events.rtc_counter_irq)
		|=> !peripheral_flag_register[`VEC_RTC_COUNTER] && !irq_request[`VEC_RTC_COUNTER]
	) else $error("Counter request stayed after its flag cleared");

	AST_SET_WINS: assert property (
		(flag_clear[`VEC_FIRST_PORT] && events.first_port_pin_irq)
		|=> peripheral_flag_register[`VEC_FIRST_PORT]
	) else $error("Clear beat a set in the same cycle");

	AST_FLAG_HOLDS: assert property (
		(peripheral_flag_register[`VEC_VOLTAGE] && !flag_clear[`VEC_VOLTAGE])
		|=> peripheral_flag_register[`VEC_VOLTAGE]
	) else $error("Flag lost without a clear");

	AST_NMI_GLOBAL: assert property (
		(!global_enable && peripheral_flag_register[`VEC_CHECKSUM]
			&& !flag_clear[`VEC_CHECKSUM])
		|=> irq_request[`VEC_CHECKSUM]
	) else $error("Checksum request masked by global enable");

	AST_NMI_FIRST: assert property (
		irq_request[`VEC_CHECKSUM]
		|-> core_request.vector == `VEC_CHECKSUM && core_request.nonmaskable
	) else $error("Checksum request not presented first");

	AST_VALID_ANY: assert property (
		core_request.valid == (irq_request != '0)
	) else $error("Core valid disagrees with pending requests");

	AST_NONMASK_FLAG: assert property (
		core_request.nonmaskable == irq_request[`VEC_CHECKSUM]
	) else $error("Unmaskable mark disagrees with vector one");

	AST_FLAGS_IMPLEMENTED: assert property (
		(peripheral_flag_register & ~`IMPLEMENTED_MASK) == '0
	) else $error("Flag set on an unmapped vector");

	AST_ENABLE_ON: assert property (
		(global_enable && peripheral_irq_enable_register[`VEC_RTC_COUNTER]
			&& peripheral_flag_register[`VEC_RTC_COUNTER]
			&& !flag_clear[`VEC_RTC_COUNTER])
		|=> irq_request[`VEC_RTC_COUNTER]
	) else $error("Enabled counter request missing");

	AST_VECTOR_RANGE: assert property (
		core_request.valid |-> core_request.vector != `VEC_RESET
			&& core_request.vector != 4'h5 && core_request.vector <= `VEC_TIMER_B
	) else $error("Presented vector outside the mapped set");

	AST_CORE_IDLE: assert property (
		(flag_clear == '1 && events == '0)
		|=> !core_request.valid && peripheral_flag_register == '0
	) else $error("Request stayed after all flags cleared");

	AST_GLOBAL_KEEPS_FLAG: assert property (
		(!global_enable && peripheral_flag_register[`VEC_RTC_COUNTER]
			&& !flag_clear[`VEC_RTC_COUNTER])
		|=> peripheral_flag_register[`VEC_RTC_COUNTER] && !irq_request[`VEC_RTC_COUNTER]
	) else $error("Global disable changed flag or raised request");

endmodule : irq_vector_logic

`default_nettype wire

// >>> core_model.sv
// Purpose: Processor core model taking vectored requests
// Assumes: Requests are registered on mclk
// Notes: Counts cycles with a valid request presented
`timescale 1ns/1ps
`default_nettype none
module core_model
	import irq_types_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Request from the interrupt logic
	input wire core_request_type core_request,
	// Acceptance count
	output logic [15:0] taken_count
);
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			taken_count <= 16'h0000;
		end else if (core_request.valid) begin
			taken_count <= taken_count + 16'h0001;
		end
	end
endmodule : core_model
`default_nettype wire

// >>> interrupt_vector_request_logic_test.sv
// Purpose: Self-checking bench for the interrupt vector logic
// Assumes: Inputs change at the rising edge by non-blocking assignment
// Notes: Event bit k of the packed struct maps through vmap
`timescale 1ns/1ps
`default_nettype none
module interrupt_vector_request_logic_test
	import irq_types_pkg::*;
;
	localparam logic [3:0] VMAP [16] = '{4'hd, 4'ha, 4'hb, 4'hc, 4'ha, 4'hb, 4'hc, 4'h9,
		4'h8, 4'h8, 4'h7, 4'h6, 4'h4, 4'h3, 4'h2, 4'h1};
	localparam logic [15:0] NORMAL_OK = 16'hfe71;
	localparam logic [15:0] SPLIT_OK = 16'hfd8f;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	irq_event_type ev = '0;
	timer_a_mode_type mode = timer_a_normal_mode;
	logic glob = 1'b1;
	logic [13:0] en = '1;
	logic [13:0] clr = '0;
	logic [13:0] flags;
	logic [13:0] req;
	core_request_type core;
	logic rent;
	logic [15:0] taken;
	int fail_count = 0;
	int checked = 0;
	always #10 mclk = ~mclk;
	irq_vector_logic #(.NUM_VECTORS(14)) u_irq_vector_logic (.mclk(mclk), .rst(rst),
		.events(ev), .timer_a_mode(mode), .global_enable(glob),
		.peripheral_irq_enable_register(en), .flag_clear(clr),
		.peripheral_flag_register(flags), .irq_request(req), .core_request(core),
		.reset_entry(rent));
	core_model u_core_model (.mclk(mclk), .rst(rst), .core_request(core), .taken_count(taken));
	task cmp_vec(input string what, input logic [15:0] exp, input logic [15:0] got);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask : cmp_vec
	task cmp_req(input string what, input core_request_type exp, input core_request_type got);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask : cmp_req
	task report_and_stop;
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : report_and_stop
	task clear_all;
		@(posedge mclk);
		clr <= '1;
		@(posedge mclk);
		clr <= '0;
	endtask : clear_all
	task test_map;
		logic [3:0] v;
		logic ok;
		for (int m = 0; m < 2; m++) begin
			for (int k = 0; k < 16; k++) begin
				v = VMAP[k];
				ok = (m == 0) ? NORMAL_OK[k] : SPLIT_OK[k];
				@(posedge mclk);
				mode <= timer_a_mode_type'(m);
				ev <= irq_event_type'(16'h0001 << k);
				@(posedge mclk);
				ev <= '0;
				#1;
				if (ok) begin
					cmp_vec("flags", 16'h0001 << v, {2'b00, flags});
					cmp_vec("request", 16'h0001 << v, {2'b00, req});
					cmp_req("core", '{1'b1, v == 4'h1, v}, core);
				end else begin
					cmp_vec("refused", 16'h0000, {2'b00, flags});
				end
				clear_all;
			end
		end
		$display("test_map done");
	endtask : test_map
	task test_global;
		logic [15:0] t0;
		@(posedge mclk);
		glob <= 1'b0;
		ev.checksum_scan_nonmaskable_irq <= 1'b1;
		ev.rtc_counter_irq <= 1'b1;
		@(posedge mclk);
		ev <= '0;
		#1;
		cmp_vec("flags", 16'h0042, {2'b00, flags});
		cmp_vec("masked", 16'h0002, {2'b00, req});
		cmp_req("core", '{1'b1, 1'b1, 4'h1}, core);
		@(posedge mclk);
		glob <= 1'b1;
		@(posedge mclk);
		en[6] <= 1'b0;
		#1;
		cmp_vec("global", 16'h0042, {2'b00, req});
		@(posedge mclk);
		en[6] <= 1'b1;
		#1;
		cmp_vec("disabled", 16'h0002, {2'b00, req});
		t0 = taken;
		repeat (3) @(posedge mclk);
		#1;
		cmp_vec("held", 16'h0042, {2'b00, req});
		cmp_vec("taken", t0 + 16'h0003, taken);
		clear_all;
		$display("test_global done");
	endtask : test_global
	task test_order;
		@(posedge mclk);
		mode <= timer_a_normal_mode;
		ev.timer_a_overflow_irq <= 1'b1;
		ev.first_port_pin_irq <= 1'b1;
		@(posedge mclk);
		ev.timer_a_overflow_irq <= 1'b0;
		clr <= 14'h0008;
		#1;
		cmp_req("lowest", '{1'b1, 1'b0, 4'h3}, core);
		@(posedge mclk);
		ev <= '0;
		#1;
		cmp_vec("set wins", 16'h0108, {2'b00, flags});
		@(posedge mclk);
		#1;
		cmp_req("next", '{1'b1, 1'b0, 4'h8}, core);
		clr <= '0;
		clear_all;
		$display("test_order done");
	endtask : test_order
	initial begin
		repeat (15) @(posedge mclk);
		#1;
		cmp_vec("entry", 16'h0001, {15'h0000, rent});
		cmp_vec("flags", 16'h0000, {2'b00, flags});
		@(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		#1;
		cmp_vec("entry", 16'h0000, {15'h0000, rent});
		cmp_vec("taken", 16'h0000, taken);
		test_map;
		test_global;
		test_order;
		report_and_stop;
	end
	initial begin
		#(20 * 4000);
		fail_count++;
		report_and_stop;
	end
endmodule : interrupt_vector_request_logic_test
`default_nettype wire
